// ==== design/clk_switch_pkg.sv ====
// Constants, encodings and state types shared by the clock switch design.
package clk_switch_pkg;

	// ****************************************************************
	// Clock source codes and control register field positions
	// ****************************************************************
	localparam logic [2:0] OSC_FRC = 3'h0;
	localparam logic [2:0] OSC_FRC_PLL = 3'h1;
	localparam logic [2:0] OSC_PRI = 3'h2;
	localparam logic [2:0] OSC_PRI_PLL = 3'h3;
	localparam logic [2:0] OSC_LP = 3'h4;
	localparam logic [2:0] OSC_LOW_POWER_RC_OSC = 3'h5;
	localparam int unsigned CUR_LSB = 12;
	localparam int unsigned NEW_LSB = 8;
	localparam int unsigned LOCK_BIT = 5;
	localparam int unsigned CF_BIT = 3;
	localparam int unsigned KEEPON_BIT = 1;
	localparam int unsigned GO_BIT = 0;

	// ****************************************************************
	// Primary submodes, source enable indices, timing and sync lanes
	// ****************************************************************
	localparam logic [1:0] SUB_EC = 2'h0;
	localparam logic [1:0] SUB_XT = 2'h1;
	localparam logic [1:0] SUB_HS = 2'h2;
	localparam logic [1:0] SRC_PRI = 2'h0;
	localparam logic [1:0] SRC_LP = 2'h1;
	localparam logic [1:0] SRC_FRC = 2'h2;
	localparam logic [1:0] SRC_LOW_POWER_RC_OSC = 2'h3;
	localparam logic [3:0] SETTLE_CYCLES = 4'ha;
	localparam int unsigned SYNC_OST = 0;
	localparam int unsigned SYNC_LOCK = 1;
	localparam int unsigned SYNC_NEWCLK = 2;
	localparam int unsigned SYNC_FAIL = 3;
	localparam int unsigned SYNC_W = 4;

	// ****************************************************************
	// Switch sequencer state
	// ****************************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_READY, ST_SETTLE} sw_state_e;

	typedef struct packed {
		sw_state_e state;
		logic [2:0] cur;
		logic [2:0] new_osc_sel;
		logic go;
		logic lock;
		logic cf;
		logic keepon;
		logic armed;
		logic [1:0] submode;
		logic [3:0] settle_cnt;
		logic [3:0] src_en;
		logic pll_en;
		logic trap;
		logic busy;
	} sw_s;

endpackage

// ==== design/sync_edge.sv ====
// Two-stage synchroniser with registered level and rising-edge outputs.
`timescale 1ns/1ps
module sync_edge #(
	parameter int unsigned W = 4
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Asynchronous inputs.
	input wire logic [W-1:0] i_async,
	// Synchronised outputs.
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] dly;
		logic [W-1:0] rise;
	} sync_s;

	sync_s s;
	sync_s next_s;

	// The first stage feeds only the second; edges are taken later.
	always_comb
	begin
		next_s.meta = i_async;
		next_s.sync = s.meta;
		next_s.dly = s.sync;
		next_s.rise = s.sync & ~s.dly;
	end

	// State register.
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign o_level = s.sync;
	assign o_rise = s.rise;

endmodule

// ==== design/clock_switch_failsafe_monitor.sv ====
// Clock source switch sequencer with fail-safe clock monitor.
//
// Contract
// - Software may select any of six source codes.
// - Primary submode fixed by configuration only.
// - Switching and monitor enabled only when cfg low.
// - Disabled: new select still written but never acted on, current shows initial.
// - Disabled: switch_go ignored and reads zero.
// - Equal selects clear go, abort as redundant.
// - Valid switch start clears lock and fail flags.
// - Start source; wait startup timer and/or PLL lock.
// - Count ten new-clock cycles before handover.
// - Success clears go, copies new to current.
// - Stop old source except kept RC/crystal.
// - Processor keeps running during a switch.
// - Monitor on: low-power RC runs except Sleep.
// - Clock failure raises trap, falls to fast RC.
// - Failure under PLL keeps fallback through PLL.
`timescale 1ns/1ps
module clock_switch_failsafe_monitor (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Configuration straps.
	input wire logic i_switch_monitor_cfg,
	input wire logic [2:0] i_initial_osc_cfg,
	input wire logic [1:0] i_primary_osc_submode_cfg,
	input wire logic i_wdt_en,
	input wire logic i_sleep,
	// Software access to the oscillator control register.
	input wire logic i_unlock,
	input wire logic i_wr_high,
	input wire logic i_wr_low,
	input wire logic [7:0] i_wdata,
	output logic [15:0] o_osc_control_reg,
	// Oscillator status, asynchronous.
	input wire logic i_ost_done,
	input wire logic i_pll_lock,
	input wire logic i_new_clk,
	input wire logic i_clk_fail,
	// Oscillator control.
	output logic [3:0] o_src_en,
	output logic o_pll_en,
	output logic [2:0] o_sys_clk_sel,
	output logic [1:0] o_primary_submode,
	output logic o_switch_busy,
	output logic o_clk_fail_trap
);

	// ****************************************************************
	// Helper functions on source codes
	// ****************************************************************
	function automatic logic [1:0] src_of(input logic [2:0] code);
		logic [1:0] r;
		r = clk_switch_pkg::SRC_FRC;
		if (code == clk_switch_pkg::OSC_PRI || code == clk_switch_pkg::OSC_PRI_PLL)
			r = clk_switch_pkg::SRC_PRI;
		else if (code == clk_switch_pkg::OSC_LP)
			r = clk_switch_pkg::SRC_LP;
		else if (code == clk_switch_pkg::OSC_LOW_POWER_RC_OSC)
			r = clk_switch_pkg::SRC_LOW_POWER_RC_OSC;
		return r;
	endfunction

	function automatic logic uses_pll(input logic [2:0] code);
		return code == clk_switch_pkg::OSC_FRC_PLL || code == clk_switch_pkg::OSC_PRI_PLL;
	endfunction

	function automatic logic needs_ost(input logic [2:0] code, input logic [1:0] sub);
		return code == clk_switch_pkg::OSC_LP
			|| (src_of(code) == clk_switch_pkg::SRC_PRI && sub != clk_switch_pkg::SUB_EC);
	endfunction

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	logic [clk_switch_pkg::SYNC_W-1:0] sync_in;
	logic [clk_switch_pkg::SYNC_W-1:0] lvl;
	logic [clk_switch_pkg::SYNC_W-1:0] rise;

	assign sync_in = {i_clk_fail, i_new_clk, i_pll_lock, i_ost_done};

	// Status pins come from other clock domains.
	sync_edge #(
		.W(clk_switch_pkg::SYNC_W)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(sync_in),
		.o_level(lvl),
		.o_rise(rise)
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	clk_switch_pkg::sw_s s;
	clk_switch_pkg::sw_s next_s;
	clk_switch_pkg::sw_s reset_s;
	logic fsm_on;
	logic fail_ev;
	logic ready;
	logic [1:0] old_src;

	assign fsm_on = ~i_switch_monitor_cfg;
	assign fail_ev = fsm_on & rise[clk_switch_pkg::SYNC_FAIL];
	assign old_src = src_of(s.cur);
	assign ready = (!needs_ost(s.new_osc_sel, s.submode) || lvl[clk_switch_pkg::SYNC_OST])
		&& (!uses_pll(s.new_osc_sel) || lvl[clk_switch_pkg::SYNC_LOCK]);

	// Reset image: the initial source runs, submode is caught from its strap.
	always_comb
	begin
		reset_s = '0;
		reset_s.state = clk_switch_pkg::ST_IDLE;
		reset_s.cur = i_initial_osc_cfg;
		reset_s.new_osc_sel = i_initial_osc_cfg;
		reset_s.submode = i_primary_osc_submode_cfg;
		reset_s.src_en[src_of(i_initial_osc_cfg)] = 1'b1;
		reset_s.pll_en = uses_pll(i_initial_osc_cfg);
	end

	// Next-state logic for writes, switch sequence and fail-safe fallback.
	always_comb
	begin
		next_s = s;
		next_s.trap = 1'b0;
		next_s.lock = lvl[clk_switch_pkg::SYNC_LOCK] & s.pll_en;
		// Each write consumes the unlock; writes without it change nothing.
		if (i_unlock)
			next_s.armed = 1'b1;
		if (i_wr_high || i_wr_low)
			next_s.armed = 1'b0;
		if (s.armed && i_wr_high && !s.busy)
			next_s.new_osc_sel = i_wdata[2:0];
		if (s.armed && i_wr_low)
		begin
			next_s.keepon = i_wdata[clk_switch_pkg::KEEPON_BIT];
			if (i_wdata[clk_switch_pkg::GO_BIT])
				next_s.go = 1'b1;
		end
		if (!fsm_on)
			next_s.go = 1'b0;
		case (s.state)
			clk_switch_pkg::ST_IDLE:
			begin
				if (s.go && s.new_osc_sel == s.cur)
					next_s.go = 1'b0;
				else if (s.go)
				begin
					next_s.lock = 1'b0;
					next_s.cf = 1'b0;
					next_s.src_en[src_of(s.new_osc_sel)] = 1'b1;
					next_s.pll_en = s.pll_en | uses_pll(s.new_osc_sel);
					next_s.busy = 1'b1;
					next_s.state = clk_switch_pkg::ST_WAIT_READY;
				end
			end
			clk_switch_pkg::ST_WAIT_READY:
			begin
				if (ready)
				begin
					next_s.settle_cnt = '0;
					next_s.state = clk_switch_pkg::ST_SETTLE;
				end
			end
			clk_switch_pkg::ST_SETTLE:
			begin
				if (rise[clk_switch_pkg::SYNC_NEWCLK])
				begin
					if (s.settle_cnt == clk_switch_pkg::SETTLE_CYCLES - 4'h1)
					begin
						next_s.cur = s.new_osc_sel;
						next_s.go = 1'b0;
						next_s.busy = 1'b0;
						next_s.pll_en = uses_pll(s.new_osc_sel);
						next_s.state = clk_switch_pkg::ST_IDLE;
						// Old source stops unless it is still wanted.
						if (old_src != src_of(s.new_osc_sel)
							&& !(old_src == clk_switch_pkg::SRC_LOW_POWER_RC_OSC && (i_wdt_en || fsm_on))
							&& !(old_src == clk_switch_pkg::SRC_LP && s.keepon))
							next_s.src_en[old_src] = 1'b0;
					end
					else
						next_s.settle_cnt = s.settle_cnt + 4'h1;
				end
			end
			default:
				next_s.state = clk_switch_pkg::ST_IDLE;
		endcase
		// A failure overrides any switch in flight.
		if (fail_ev)
		begin
			next_s.cur = uses_pll(s.cur) ? clk_switch_pkg::OSC_FRC_PLL
				: clk_switch_pkg::OSC_FRC;
			next_s.pll_en = uses_pll(s.cur);
			next_s.src_en[clk_switch_pkg::SRC_FRC] = 1'b1;
			next_s.cf = 1'b1;
			next_s.trap = 1'b1;
			next_s.go = 1'b0;
			next_s.busy = 1'b0;
			next_s.state = clk_switch_pkg::ST_IDLE;
		end
		if (fsm_on && !i_sleep)
			next_s.src_en[clk_switch_pkg::SRC_LOW_POWER_RC_OSC] = 1'b1;
	end

	// State register.
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			s <= reset_s;
		else
			s <= next_s;
	end

	// Outputs are fields of the state register.
	assign o_osc_control_reg = {1'b0, s.cur, 1'b0, s.new_osc_sel, 2'h0, s.lock, 1'b0, s.cf,
		1'b0, s.keepon, s.go};
	assign o_src_en = s.src_en;
	assign o_pll_en = s.pll_en;
	assign o_sys_clk_sel = s.cur;
	assign o_primary_submode = s.submode;
	assign o_switch_busy = s.busy;
	assign o_clk_fail_trap = s.trap;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence seq_valid_start;
		s.state == clk_switch_pkg::ST_IDLE && s.go && s.new_osc_sel != s.cur && !fail_ev;
	endsequence

	sequence seq_handover;
		s.state == clk_switch_pkg::ST_SETTLE && rise[clk_switch_pkg::SYNC_NEWCLK]
			&& s.settle_cnt == clk_switch_pkg::SETTLE_CYCLES - 4'h1 && !fail_ev;
	endsequence

	property p_disabled_frozen;
		@(posedge i_core_clk) disable iff (i_srst)
		i_switch_monitor_cfg |=> !s.go && $stable(s.cur);
	endproperty
	a_disabled_frozen: assert property (p_disabled_frozen) else $error("switch active while disabled");

	property p_submode_fixed;
		@(posedge i_core_clk) disable iff (i_srst)
		1'b1 |=> $stable(o_primary_submode);
	endproperty
	a_submode_fixed: assert property (p_submode_fixed) else $error("primary submode changed");

	property p_redundant;
		@(posedge i_core_clk) disable iff (i_srst)
		s.state == clk_switch_pkg::ST_IDLE && s.go && s.new_osc_sel == s.cur && !fail_ev
		|=> !s.go && s.state == clk_switch_pkg::ST_IDLE;
	endproperty
	a_redundant: assert property (p_redundant) else $error("redundant switch not aborted");

	property p_start_clears;
		@(posedge i_core_clk) disable iff (i_srst)
		seq_valid_start |=> !s.cf && !s.lock && s.state == clk_switch_pkg::ST_WAIT_READY;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start did not clear flags");

	property p_pll_wait;
		@(posedge i_core_clk) disable iff (i_srst)
		s.state == clk_switch_pkg::ST_WAIT_READY && uses_pll(s.new_osc_sel)
			&& !lvl[clk_switch_pkg::SYNC_LOCK] |=> s.state != clk_switch_pkg::ST_SETTLE;
	endproperty
	a_pll_wait: assert property (p_pll_wait) else $error("settle entered before lock");

	property p_handover;
		@(posedge i_core_clk) disable iff (i_srst)
		seq_handover |=> s.cur == $past(s.new_osc_sel) && !s.go && !s.busy;
	endproperty
	a_handover: assert property (p_handover) else $error("handover wrong");

	property p_fail_fallback;
		@(posedge i_core_clk) disable iff (i_srst)
		fail_ev |=> o_clk_fail_trap && s.cf && s.src_en[clk_switch_pkg::SRC_FRC]
			&& s.cur == ($past(uses_pll(s.cur)) ? clk_switch_pkg::OSC_FRC_PLL
			: clk_switch_pkg::OSC_FRC) ##1 !o_clk_fail_trap;
	endproperty
	a_fail_fallback: assert property (p_fail_fallback) else $error("fail-safe fallback wrong");

	property p_low_power_rc_osc_on;
		@(posedge i_core_clk) disable iff (i_srst)
		!i_srst && fsm_on && !i_sleep |=> s.src_en[clk_switch_pkg::SRC_LOW_POWER_RC_OSC];
	endproperty
	a_low_power_rc_osc_on: assert property (p_low_power_rc_osc_on) else $error("low-power RC stopped");

	property p_locked_write;
		@(posedge i_core_clk) disable iff (i_srst)
		(i_wr_high || i_wr_low) && !s.armed |=> $stable(s.new_osc_sel) && $stable(s.keepon);
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("write without unlock");

	property p_old_stop;
		@(posedge i_core_clk) disable iff (i_srst)
		seq_handover and (old_src == clk_switch_pkg::SRC_PRI && src_of(s.new_osc_sel) != old_src)
		|=> !s.src_en[clk_switch_pkg::SRC_PRI];
	endproperty
	a_old_stop: assert property (p_old_stop) else $error("old primary not stopped");

endmodule

// ==== sim/osc_partner.sv ====
// Behavioural model of the oscillators, PLL and failure detector around the block.
`timescale 1ns/1ps
module osc_partner #(
	parameter int unsigned OST_CYC = 20,
	parameter int unsigned LOCK_CYC = 15
) (
	// Clock.
	input wire logic i_core_clk,
	// Controls from the block and the bench.
	input wire logic [3:0] i_src_en,
	input wire logic i_pll_en,
	input wire logic i_fail,
	// Status towards the block.
	output logic o_ost_done,
	output logic o_pll_lock,
	output logic o_new_clk,
	output logic o_clk_fail
);
	int ost_cnt = 0;
	int lock_cnt = 0;
	int div = 0;
	logic nclk_q = 1'b0;

	// Crystals report ready after a start-up delay, the PLL after lock time.
	// The new clock is an oscillator, so it runs free at an eighth of the core rate.
	always @(posedge i_core_clk)
	begin
		ost_cnt <= (i_src_en[0] | i_src_en[1]) ? ost_cnt + 1 : 0;
		lock_cnt <= i_pll_en ? lock_cnt + 1 : 0;
		div <= (div == 3) ? 0 : div + 1;
		if (div == 3)
			nclk_q <= ~nclk_q;
	end

	// The new source clock leaves the model straight from its toggle flop.
	assign o_new_clk = nclk_q;

	// Status levels follow the counters and the bench's failure request.
	assign o_ost_done = (ost_cnt >= OST_CYC);
	assign o_pll_lock = (lock_cnt >= LOCK_CYC);
	assign o_clk_fail = i_fail;
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the clock switch sequencer and fail-safe monitor.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cfg = 1'b0;
	logic [2:0] init = clk_switch_pkg::OSC_FRC;
	logic unlock = 1'b0;
	logic wr_high = 1'b0;
	logic wr_low = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic fail = 1'b0;
	logic osc_startup_timer, lock, nclk, cfail, pll_en, busy, trap, prev = 1'b0;
	logic [15:0] reg_v;
	logic [3:0] src_en;
	logic [2:0] sel;
	logic [1:0] sub;
	int err_count = 0;
	int comparisons = 0;
	int rises = 0;
	int n;

	// ****************************************************************
	// Clock, design and oscillator model
	// ****************************************************************
	always #5 clk = ~clk;

	clock_switch_failsafe_monitor dut (.i_core_clk(clk), .i_srst(srst),
		.i_switch_monitor_cfg(cfg), .i_initial_osc_cfg(init),
		.i_primary_osc_submode_cfg(clk_switch_pkg::SUB_HS), .i_wdt_en(1'b0),
		.i_sleep(1'b0), .i_unlock(unlock), .i_wr_high(wr_high), .i_wr_low(wr_low),
		.i_wdata(wdata), .o_osc_control_reg(reg_v), .i_ost_done(osc_startup_timer),
		.i_pll_lock(lock), .i_new_clk(nclk), .i_clk_fail(cfail), .o_src_en(src_en),
		.o_pll_en(pll_en), .o_sys_clk_sel(sel), .o_primary_submode(sub),
		.o_switch_busy(busy), .o_clk_fail_trap(trap));

	osc_partner osc (.i_core_clk(clk), .i_src_en(src_en), .i_pll_en(pll_en),
		.i_fail(fail), .o_ost_done(osc_startup_timer), .o_pll_lock(lock), .o_new_clk(nclk),
		.o_clk_fail(cfail));

	// Counts new-clock rises seen while the new source is ready and a switch runs.
	always @(posedge clk)
	begin
		prev <= nclk;
		if (!busy)
			rises <= 0;
		else if (osc_startup_timer && (lock || !pll_en) && nclk && !prev)
			rises <= rises + 1;
	end

	// ****************************************************************
	// Access and checking tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic do_reset();
		srst <= 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	// One byte write, preceded by an unlock pulse when armed is set.
	task automatic wr(input logic high, input logic armed, input logic [7:0] d);
		@(posedge clk);
		if (armed)
		begin
			unlock <= 1'b1;
			@(posedge clk);
			unlock <= 1'b0;
		end
		wr_high <= high;
		wr_low <= !high;
		wdata <= d;
		@(posedge clk);
		wr_high <= 1'b0;
		wr_low <= 1'b0;
		@(posedge clk);
		@(negedge clk);
	endtask

	// Full software sequence for a switch, then a bounded wait for its end.
	// The start flags are looked at in the cycle right after the start, before lock returns.
	task automatic switch_to(input logic [2:0] code, input logic timed, input logic keep);
		wr(1'b1, 1'b1, {5'h00, code});
		wr(1'b0, 1'b1, {6'h00, keep, 1'b1});
		chk("busy at start", 16'h0001, {15'h0000, busy});
		chk("lock and fail flags", 16'h0000, reg_v & 16'h0028);
		n = 0;
		while (busy && n < 2000)
		begin
			@(negedge clk);
			n++;
			if (busy && timed)
				chk("settle rises", 16'h0001, {15'h0000, rises <= 10});
		end
		chk("switch finished", 16'h0000, {15'h0000, busy});
		if (timed)
			chk("rises at handover", 16'h0001, {15'h0000, rises >= 10});
		chk("current after switch", {13'h0000, code}, {13'h0000, reg_v[14:12]});
		chk("go after switch", 16'h0000, {15'h0000, reg_v[0]});
		chk("system select", {13'h0000, code}, {13'h0000, sel});
	endtask

	task automatic tend(input string name);
		$display("test %s finished", name);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************************************
	// Test sequence and watchdog
	// ****************************************************************
	initial
	begin
		do_reset();
		chk("reset register", 16'h0000, reg_v);
		chk("reset sources", 16'h000c, {12'h000, src_en});
		chk("submode", {14'h0000, clk_switch_pkg::SUB_HS}, {14'h0000, sub});
		wr(1'b1, 1'b0, 8'h02);
		chk("unarmed write", 16'h0000, reg_v);
		wr(1'b1, 1'b1, 8'h00);
		wr(1'b0, 1'b1, 8'h01);
		repeat (3) @(negedge clk);
		chk("redundant go", 16'h0000, {15'h0000, reg_v[0]});
		chk("redundant busy", 16'h0000, {15'h0000, busy});
		tend("reset and redundant");
		switch_to(clk_switch_pkg::OSC_PRI, 1'b1, 1'b0);
		chk("old source off", 16'h0009, {12'h000, src_en});
		switch_to(clk_switch_pkg::OSC_PRI_PLL, 1'b1, 1'b0);
		chk("pll on and locked", 16'h0021, {10'h000, reg_v[5], 4'h0, pll_en});
		tend("switch to crystal and pll");
		@(posedge clk);
		fail <= 1'b1;
		n = 0;
		while (trap !== 1'b1 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		chk("trap raised", 16'h0001, {15'h0000, trap});
		@(negedge clk);
		chk("trap one cycle", 16'h0000, {15'h0000, trap});
		chk("fallback source", {13'h0000, clk_switch_pkg::OSC_FRC_PLL},
			{13'h0000, reg_v[14:12]});
		chk("fail flag and fast rc", 16'h0011, {11'h000, reg_v[3], 3'h0, src_en[2]});
		@(posedge clk);
		fail <= 1'b0;
		switch_to(clk_switch_pkg::OSC_FRC, 1'b0, 1'b0);
		chk("fail flag cleared", 16'h0000, {15'h0000, reg_v[3]});
		chk("pll off", 16'h0000, {15'h0000, pll_en});
		tend("failure and recovery");
		// The primary stops when left; the low-power crystal stays on with keep-on set.
		switch_to(clk_switch_pkg::OSC_PRI, 1'b0, 1'b0);
		switch_to(clk_switch_pkg::OSC_LP, 1'b0, 1'b1);
		chk("old primary off", 16'h000a, {12'h000, src_en});
		switch_to(clk_switch_pkg::OSC_LOW_POWER_RC_OSC, 1'b0, 1'b1);
		chk("crystal kept on", 16'h000a, {12'h000, src_en});
		chk("keep-on bit", 16'h0001, {15'h0000, reg_v[1]});
		tend("keep-on sources");
		@(posedge clk);
		cfg <= 1'b1;
		init <= clk_switch_pkg::OSC_LP;
		do_reset();
		chk("disabled current", 16'h0004, {13'h0000, reg_v[14:12]});
		wr(1'b1, 1'b1, 8'h00);
		wr(1'b0, 1'b1, 8'h01);
		chk("disabled go", 16'h0000, {15'h0000, reg_v[0]});
		@(posedge clk);
		fail <= 1'b1;
		repeat (8) @(negedge clk);
		chk("disabled select", 16'h0004, {13'h0000, sel});
		chk("disabled monitor", 16'h0000, {14'h0000, trap, reg_v[3]});
		tend("switching disabled");
		conclude();
	end

	initial
	begin
		#300000;
		err_count++;
		conclude();
	end
endmodule
